/* File: verif/pbc_loop_model.sv */
// Purpose: Analog loop and system integration stand-in
// Assumes: Lock follows loop enable after a settable delay
// Notes:   Clocks stand still while their source is off
module pbc_loop_model
  import pbc_pkg::*;
#(
  parameter int LOCK_DLY = 8
)(
  input  wire logic                pclk,
  input  wire logic                lock_goal,
  input  wire logic                xtal_ok,
  input  wire logic                osc_en,
  input  wire logic                brk,
  input  wire pbc_pkg::pbc_loop_s  loop_in,
  output pbc_pkg::pbc_analog_s     ana,
  output logic                     vco_clock,
  output logic                     crystal_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial begin
    vco_clock = 1'b0;
    crystal_clock = 1'b0;
  end
  always @(posedge pclk) begin
    cnt <= (loop_in.loop_enable === 1'b1 && lock_goal) ? cnt + 1 : 0;
  end
  // Tracking comes halfway to lock; levels only
  assign ana = {cnt >= LOCK_DLY, cnt >= LOCK_DLY / 2, xtal_ok, osc_en, brk};
  always #3 crystal_clock = osc_en & xtal_ok & ~crystal_clock;
  always #1.8 vco_clock = (loop_in.loop_enable === 1'b1) & ~vco_clock;
endmodule

/* File: verif/pbc_top_asserts.sv */
// Purpose: Port-level checks bound to pbc_top
// Assumes: Register outputs settle one edge after the bus write
// Notes:   Stop checks allow the two-flop enable synchroniser
module pbc_top_asserts
  import pbc_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire pbc_pkg::pbc_analog_s ana_in,
  input wire logic                base_clock_out,
  input wire logic                clock_unit_irq,
  input wire pbc_pkg::pbc_loop_s  loop_out
);
  logic acc_rd;
  logic map_hit;
  assign acc_rd  = psel && penable && !pwrite;
  assign map_hit = paddr inside {PBC_OFS_LOOP_CTRL, PBC_OFS_BW_CTRL, PBC_OFS_MUL_PROG, PBC_OFS_BRK_CTRL};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  mul_nonzero_a: assert property (loop_out.feedback_multiplier != 4'h0)
    else $error("multiplier output is zero");
  mul_frozen_a: assert property (loop_out.loop_enable |=> $stable(loop_out.feedback_multiplier))
    else $error("multiplier changed with loop on");
  range_frozen_a: assert property (loop_out.loop_enable |=> $stable(loop_out.vco_range_select))
    else $error("range changed with loop on");
  range_zero_off_a: assert property (loop_out.vco_range_select == 4'h0 |-> !loop_out.loop_enable && !loop_out.vco_select)
    else $error("loop active with zero range");
  manual_unlocked_a: assert property (acc_rd && paddr == PBC_OFS_BW_CTRL && !prdata[PBC_BW_AUTO] |-> !prdata[PBC_BW_LOCK])
    else $error("settled flag set in manual mode");
  stop_quiet_a: assert property (!ana_in.osc_enable_from_sysint [*3] |-> !base_clock_out && !clock_unit_irq)
    else $error("output active in stop");
  stop_desel_a: assert property (!ana_in.osc_enable_from_sysint [*4] |-> !loop_out.vco_select)
    else $error("vco still selected in stop");
  unmapped_read_a: assert property (acc_rd && !map_hit |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped read not refused");
endmodule

bind pbc_top pbc_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .ana_in(ana_in),
  .base_clock_out(base_clock_out), .clock_unit_irq(clock_unit_irq), .loop_out(loop_out));

/* File: verif/pbc_top_test.sv */
// Purpose: Self-checking bench for pbc_top
// Assumes: Loop control expectations kept in plain ints
// Notes:   Lock timing comes from the loop model delay
module pbc_top_test
  import pbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00, q, v;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, vco_clock, crystal_clock, base_clock_out, clock_unit_irq;
  logic        lock_goal = 0, xtal_ok = 1, osc_en = 1, brk = 0;
  pbc_analog_s ana;
  pbc_loop_s   lo;
  int          mismatches = 0, n_compared = 0, seed = 57, mul = 3;
  int          au = 0, ien = 0, flag = 0, pwr = 1, bsel = 0, vrs = 6;
  pbc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ana_in(ana),
    .vco_clock(vco_clock), .crystal_clock(crystal_clock), .crystal_clock_out(),
    .base_clock_out(base_clock_out), .clock_unit_irq(clock_unit_irq), .loop_out(lo));
  pbc_loop_model #(.LOCK_DLY(8)) far_u (.pclk(pclk), .lock_goal(lock_goal), .xtal_ok(xtal_ok),
    .osc_en(osc_en), .brk(brk), .loop_in(lo), .ana(ana), .vco_clock(vco_clock), .crystal_clock(crystal_clock));
  // ==========================================================
  // Bus tasks and model
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      end_sim();
    end
    q = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic lc_wr(input logic [7:0] d);
    int p;
    p = pwr;
    wr(PBC_OFS_LOOP_CTRL, d);
    ien = au & d[7];
    pwr = bsel | d[5];
    bsel = d[4] & p & (vrs != 0);
    flag = 0;
  endtask
  function automatic logic [7:0] lcv();
    return {ien[0], flag[0], pwr[0], bsel[0], 4'hF};
  endfunction
  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, lcv());
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h66);
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
    chk({7'h0, err}, 8'h01);
    wr(8'h08, 8'h11);
    rd(8'h08, 8'h66);
    lc_wr(8'h00);
    wr(8'h04, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(8'h08, v);
      rd(8'h08, v);
      chk({4'h0, lo.feedback_multiplier}, {4'h0, v[7:4] == 4'h0 ? 4'h1 : v[7:4]});
    end
    wr(8'h08, 8'h05);
    chk({4'h0, lo.feedback_multiplier}, 8'h01);
    wr(8'h08, 8'h30);
    vrs = 0;
    lc_wr(8'h20);
    lc_wr(8'h30);
    rd(8'h00, lcv());
    chk({7'h0, lo.loop_enable}, 8'h00);
    wr(8'h08, 8'h36);
    rd(8'h08, 8'h30);
    lc_wr(8'h00);
    wr(8'h08, 8'h36);
    vrs = 6;
    lc_wr(8'h20);
    wr(8'h04, 8'h80);
    au = 1;
    lc_wr(8'hA0);
    lock_goal <= 1'b1;
    repeat (16) @(posedge pclk);
    flag = 1;
    chk({7'h0, clock_unit_irq}, 8'h01);
    rd(8'h04, 8'hE0);
    rd(8'h00, lcv());
    flag = 0;
    rd(8'h00, lcv());
    chk({7'h0, clock_unit_irq}, 8'h00);
    lc_wr(8'hB0);
    rd(8'h00, lcv());
    brk <= 1'b1;
    lock_goal <= 1'b0;
    repeat (8) @(posedge pclk);
    flag = 1;
    rd(8'h00, lcv());
    rd(8'h00, lcv());
    wr(8'h0C, 8'h80);
    rd(8'h00, lcv());
    flag = 0;
    rd(8'h00, lcv());
    brk <= 1'b0;
    wr(8'h0C, 8'h00);
    xtal_ok <= 1'b0;
    wr(8'h04, 8'h90);
    repeat (4 * mul + 4) @(posedge pclk);
    rd(8'h04, 8'h90);
    xtal_ok <= 1'b1;
    wr(8'h04, 8'h90);
    repeat (4 * mul + 4) @(posedge pclk);
    rd(8'h04, 8'h80);
    lock_goal <= 1'b1;
    lc_wr(8'h30);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h20);
    au = 0;
    repeat (16) @(posedge pclk);
    rd(8'h04, 8'h20);
    chk({7'h0, lo.force_track}, 8'h01);
    chk({7'h0, clock_unit_irq}, 8'h00);
    rd(8'h00, lcv());
    lc_wr(8'h20);
    wr(8'h04, 8'h10);
    rd(8'h04, 8'h00);
    chk({7'h0, lo.force_track}, 8'h00);
    lc_wr(8'h30);
    osc_en <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (i > 3) chk({6'h0, base_clock_out, clock_unit_irq}, 8'h00);
    end
    osc_en <= 1'b1;
    repeat (4) @(posedge pclk);
    bsel = 0;
    rd(8'h00, lcv());
    end_sim();
  end
endmodule

/* File: verilog/pbc_pkg.sv */
// Purpose: Constants and carrier types for the loop clock control block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Offsets below are byte addresses
package pbc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] PBC_OFS_LOOP_CTRL = 8'h00;
  localparam logic [7:0] PBC_OFS_BW_CTRL   = 8'h04;
  localparam logic [7:0] PBC_OFS_MUL_PROG  = 8'h08;
  localparam logic [7:0] PBC_OFS_BRK_CTRL  = 8'h0C;

  // ==========================================================
  // Loop control register fields
  localparam int PBC_LC_IRQ_EN   = 7;
  localparam int PBC_LC_FLAG     = 6;
  localparam int PBC_LC_PWR_ON   = 5;
  localparam int PBC_LC_BASE_SEL = 4;
  localparam logic [3:0] PBC_LC_UNUSED_VAL = 4'hF;

  // Bandwidth control register fields
  localparam int PBC_BW_AUTO  = 7;
  localparam int PBC_BW_LOCK  = 6;
  localparam int PBC_BW_TRACK = 5;
  localparam int PBC_BW_XLOSS = 4;

  // Multiplier program register fields
  localparam int PBC_MP_MUL_LSB = 4;
  localparam int PBC_MP_VRS_LSB = 0;

  // Break flag control register field
  localparam int PBC_BK_CLR_EN = 7;

  // ==========================================================
  // Reset values
  localparam logic [3:0] PBC_MUL_RST   = 4'h6;
  localparam logic [3:0] PBC_VRS_RST   = 4'h6;
  localparam logic       PBC_PWR_RST   = 1'b1;

  // Crystal-loss check window: 4 times N vco cycles, modelled in bus cycles
  localparam int PBC_XLOSS_FACTOR = 4;

  // ==========================================================
  // Inputs from the analog loop and system integration module
  typedef struct packed {
    logic lock_det;
    logic track_det;
    logic xtal_active;
    logic osc_enable_from_sysint;
    logic break_state;
  } pbc_analog_s;

  // Outputs to the analog loop and clock tree
  typedef struct packed {
    logic       loop_enable;
    logic       vco_select;
    logic       force_track;
    logic [3:0] feedback_multiplier;
    logic [3:0] vco_range_select;
    logic       clock_gate_n_unused;
  } pbc_loop_s;

endpackage

/* File: verilog/pbc_top.sv */
// Purpose: Register and status logic for a loop-based clock generator
// Assumes: Lock, tracking and crystal activity arrive from another domain
// Notes:   Clock switching itself is analog; this drives its select lines
// Notes:   The tracking bit is held from the mode in force before a write;
//          a write that leaves automatic mode does not load it as well.
// Function
// - Self bandwidth bit, read/write, reset manual
// - Automatic: settled flag mirrors lock state
// - Manual: settled flag reads zero
// - Automatic: tracking select reports loop mode
// - Manual: tracking select is written, forces mode
// - Hold manual tracking value; reset clears
// - Crystal loss check after 4N wait
// - Crystal loss reads zero unless VCO selected
// - Multiplier zero acts as one; reset six
// - Multiplier writes ignored while loop powered
// - Range select writes ignored while powered; reset six
// - Range zero disables loop, blocks VCO select
// - Automatic: settled change sets lock flag
// - Manual: no lock interrupt, flag reads zero
// - Wait mode leaves state unchanged
// - Stop mode holds clock, interrupt and loop enable outputs low
// - Stop entry clears base select; a later loop control write can set it again
// - Break protects lock flag unless enabled
// - Loop control read clears lock flag
// - Base clock is selected source halved
// - Power and base select interlock
module pbc_top
  import pbc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire pbc_pkg::pbc_analog_s ana_in,
  input  wire logic               vco_clock,
  input  wire logic               crystal_clock,
  output logic                    crystal_clock_out,
  output logic                    base_clock_out,
  output logic                    clock_unit_irq,
  output pbc_pkg::pbc_loop_s      loop_out
);
  import pbc_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       lock_s;
  logic       track_s;
  logic       xtal_s;
  logic       osc_en_s;
  logic       brk_s;
  logic [4:0] ana_bits;

  assign ana_bits = ana_in;

  // Two flops per level, each bit on its own
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= ana_bits[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign {lock_s, track_s, xtal_s, osc_en_s, brk_s} = sync2_reg;

  // ==========================================================
  // APB decode
  logic wr_acc;
  logic rd_acc;
  logic sel_lc;
  logic sel_bw;
  logic sel_mp;
  logic sel_bk;
  logic addr_ok;

  assign sel_lc  = paddr == PBC_OFS_LOOP_CTRL;
  assign sel_bw  = paddr == PBC_OFS_BW_CTRL;
  assign sel_mp  = paddr == PBC_OFS_MUL_PROG;
  assign sel_bk  = paddr == PBC_OFS_BRK_CTRL;
  assign addr_ok = sel_lc | sel_bw | sel_mp | sel_bk;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // ==========================================================
  // Control registers
  logic       auto_reg;
  logic       irq_en_reg;
  logic       pwr_on_reg;
  logic       base_sel_reg;
  logic       track_hold_reg;
  logic [3:0] mul_reg;
  logic [3:0] vrs_reg;
  logic       brk_clr_en_reg;
  logic       settled_reg;
  logic       flag_reg;
  logic       xloss_reg;
  logic [5:0] xloss_cnt_reg;
  logic       stopped_reg;
  logic       stop_entry;
  logic       vrs_zero;

  assign vrs_zero   = vrs_reg == 4'h0;
  assign stop_entry = ~osc_en_s & ~stopped_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopped_reg <= 1'b0;
    end else begin
      stopped_reg <= ~osc_en_s;
    end
  end

  // Bandwidth mode select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_reg <= 1'b0;
    end else if (wr_acc && sel_bw) begin
      auto_reg <= pwdata[PBC_BW_AUTO];
    end
  end

  // Manual tracking value; kept untouched while automatic mode runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_hold_reg <= 1'b0;
    end else if (wr_acc && sel_bw && !auto_reg) begin
      track_hold_reg <= pwdata[PBC_BW_TRACK];
    end
  end

  // Interrupt enable, writable only in automatic mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= 1'b0;
    end else if (!auto_reg) begin
      irq_en_reg <= 1'b0;
    end else if (wr_acc && sel_lc) begin
      irq_en_reg <= pwdata[PBC_LC_IRQ_EN];
    end
  end

  // Loop power; wait mode has no input here, so only writes move it
  // Power cannot be cleared by a write made while the VCO already drives the base clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_on_reg <= PBC_PWR_RST;
    end else if (!stop_entry && wr_acc && sel_lc) begin
      pwr_on_reg <= pwdata[PBC_LC_PWR_ON] | base_sel_reg;
    end
  end

  // Base select: stop entry and a zero range both force the crystal source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_sel_reg <= 1'b0;
    end else if (stop_entry) begin
      base_sel_reg <= 1'b0;
    end else if (wr_acc && sel_lc) begin
      base_sel_reg <= pwdata[PBC_LC_BASE_SEL] & pwr_on_reg & ~vrs_zero;
    end else if (vrs_zero) begin
      base_sel_reg <= 1'b0;
    end
  end

  // Multiplier, locked while loop is powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mul_reg <= PBC_MUL_RST;
    end else if (wr_acc && sel_mp && !pwr_on_reg) begin
      mul_reg <= pwdata[PBC_MP_MUL_LSB +: 4];
    end
  end

  // Range select, locked while loop is powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vrs_reg <= PBC_VRS_RST;
    end else if (wr_acc && sel_mp && !pwr_on_reg) begin
      vrs_reg <= pwdata[PBC_MP_VRS_LSB +: 4];
    end
  end

  // Break clear enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_clr_en_reg <= 1'b0;
    end else if (wr_acc && sel_bk) begin
      brk_clr_en_reg <= pwdata[PBC_BK_CLR_EN];
    end
  end

  // ==========================================================
  // Lock status and change flag
  logic flag_clr;
  logic flag_set;

  assign flag_clr = psel & penable & sel_lc & (~brk_s | brk_clr_en_reg);
  assign flag_set = auto_reg & (lock_s != settled_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settled_reg <= 1'b0;
    end else begin
      settled_reg <= auto_reg & lock_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (!auto_reg) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Crystal loss check: write 1 arms, 4N cycles later sample activity
  logic [5:0] n_eff;
  logic       xloss_arm;

  assign n_eff     = (mul_reg == 4'h0) ? 6'd1 : {2'b00, mul_reg};
  assign xloss_arm = wr_acc & sel_bw & pwdata[PBC_BW_XLOSS];

  // Wait counter; 4N fits in six bits for every multiplier value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xloss_cnt_reg <= 6'h00;
    end else if (!base_sel_reg) begin
      xloss_cnt_reg <= 6'h00;
    end else if (xloss_arm) begin
      xloss_cnt_reg <= 6'(PBC_XLOSS_FACTOR) * n_eff;
    end else if (xloss_cnt_reg != 6'h00) begin
      xloss_cnt_reg <= xloss_cnt_reg - 6'h01;
    end
  end

  // Loss flag reads 1 from arming until the window closes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xloss_reg <= 1'b0;
    end else if (!base_sel_reg) begin
      xloss_reg <= 1'b0;
    end else if (xloss_arm) begin
      xloss_reg <= 1'b1;
    end else if (xloss_cnt_reg == 6'h01) begin
      xloss_reg <= ~xtal_s;
    end
  end

  // ==========================================================
  // Read data
  logic       track_rd;
  logic [7:0] rd_lc;
  logic [7:0] rd_bw;
  logic [7:0] rd_mp;
  logic [7:0] rd_bk;
  logic [7:0] rd_byte;

  assign track_rd = auto_reg ? track_s : track_hold_reg;
  assign rd_lc    = {irq_en_reg, flag_reg & auto_reg, pwr_on_reg, base_sel_reg, PBC_LC_UNUSED_VAL};
  assign rd_bw    = {auto_reg, settled_reg, track_rd, xloss_reg & base_sel_reg, 4'h0};
  assign rd_mp    = {mul_reg, vrs_reg};
  assign rd_bk    = {brk_clr_en_reg, 7'h00};

  // Unmapped addresses read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (sel_lc) begin
      rd_byte = rd_lc;
    end else if (sel_bw) begin
      rd_byte = rd_bw;
    end else if (sel_mp) begin
      rd_byte = rd_mp;
    end else if (sel_bk) begin
      rd_byte = rd_bk;
    end
  end

  // Loaded in the setup cycle, so a loop control read still shows the flag
  // that its own access phase clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // ==========================================================
  // Clock outputs: base clock halves selected source, crystal passes through; both held low in stop
  logic vco_div_reg;
  logic xtal_div_reg;

  always_ff @(posedge vco_clock or negedge presetn) begin
    if (!presetn) begin
      vco_div_reg <= 1'b0;
    end else begin
      vco_div_reg <= ~vco_div_reg;
    end
  end

  always_ff @(posedge crystal_clock or negedge presetn) begin
    if (!presetn) begin
      xtal_div_reg <= 1'b0;
    end else begin
      xtal_div_reg <= ~xtal_div_reg;
    end
  end

  assign base_clock_out    = osc_en_s & (base_sel_reg ? vco_div_reg : xtal_div_reg);
  assign crystal_clock_out = osc_en_s & crystal_clock;
  assign clock_unit_irq    = osc_en_s & flag_reg & irq_en_reg & auto_reg;

  assign loop_out.loop_enable         = pwr_on_reg & ~vrs_zero & osc_en_s;
  assign loop_out.vco_select          = base_sel_reg;
  assign loop_out.force_track         = auto_reg ? 1'b0 : track_hold_reg;
  assign loop_out.feedback_multiplier = n_eff[3:0];
  assign loop_out.vco_range_select    = vrs_reg;
  assign loop_out.clock_gate_n_unused = 1'b1;

endmodule
